// ---- pkg/rct_pkg.sv ----
package rct_pkg;

  // ****************************************************
  // Register map and fields
  // ****************************************************
  localparam logic [7:0]  RCT_OFS_CTL      = 8'h80;
  localparam logic [7:0]  RCT_OFS_IEN      = 8'h84;
  localparam logic [7:0]  RCT_OFS_STS      = 8'h88;
  localparam int          RCT_CTL_REFSEL   = 10;
  localparam int          RCT_CTL_STOP     = 8;
  localparam int          RCT_CTL_RETRY    = 6;
  localparam int          RCT_CTL_AVG      = 4;
  localparam int          RCT_CTL_FREQ     = 0;
  localparam int          RCT_IEN_CLK      = 2;
  localparam int          RCT_IEN_FAIL     = 1;
  localparam int          RCT_STS_ERR      = 2;
  localparam int          RCT_STS_FAIL     = 1;
  localparam int          RCT_STS_LOCK     = 0;
  localparam logic [31:0] RCT_CTL_RST      = 32'h0000_0000;
  localparam logic [31:0] RCT_IEN_RST      = 32'h0000_0000;
  localparam logic [31:0] RCT_STS_RST      = 32'h0000_0000;
  localparam logic [9:0]  RCT_TRIM_RST     = 10'h200;

  // ****************************************************
  // Modes and counts
  // ****************************************************
  localparam logic [1:0]  RCT_FREQ_OFF     = 2'h0;
  localparam logic [1:0]  RCT_FREQ_48M     = 2'h2;
  localparam logic [9:0]  RCT_RETRY_BASE   = 10'h040;
  localparam logic [5:0]  RCT_AVG_BASE     = 6'h04;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int          RCT_CLK_HZ       = 25_000_000;
  localparam int          RCT_OSC_HZ       = 48_000_000;
  localparam int          RCT_XTAL_HZ      = 32_768;
  localparam int          RCT_SOF_HZ       = 1_000;
  localparam logic [23:0] RCT_PER_XTAL     = 24'((RCT_OSC_HZ + RCT_XTAL_HZ / 2) / RCT_XTAL_HZ);
  localparam logic [23:0] RCT_PER_SOF      = 24'(RCT_OSC_HZ / RCT_SOF_HZ);
  localparam int          RCT_REF_TMO_US   = 2_000;
  localparam int          RCT_REF_TMO_CYC  = RCT_REF_TMO_US * (RCT_CLK_HZ / 1_000_000);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic        refsel;
    logic        stop;
    logic [1:0]  retry;
    logic [1:0]  avg;
    logic [1:0]  freq;
    logic        ie_clk;
    logic        ie_fail;
    logic        f_err;
    logic        f_fail;
    logic        f_lock;
    logic        xtal_s1;
    logic        xtal_s2;
    logic        sof_s1;
    logic        sof_s2;
    logic        ref_prev;
    logic [23:0] osc_s1;
    logic [23:0] osc_s2;
    logic [9:0]  trim;
    logic [9:0]  upd_cnt;
    logic [5:0]  per_cnt;
    logic [23:0] start;
    logic        armed;
    logic        locked;
    logic        err_once;
    logic        irq;
    logic [15:0] tmo;
  } rct_state_t;

endpackage

// ---- hdl/rct_trim.sv ----
`timescale 1ns/1ns
// What this block does
// - Reference select picks crystal or USB frames
// - Stop-on-error set: error stops trim, clears target
// - Locked, no stop: flag once, suspend till recovery
// - Retry field sets 64/128/256/512 update limit
// - Reaching lock clears the update counter
// - Limit reached unlocked: disable, clear target
// - Averaging field sets 4/8/16/32 reference periods
// - Target 00 disables, 10 trims to 48 MHz
// - Clock error flag and enable raise interrupt
// - Failure flag and enable raise interrupt
// - Unreasonable frequency or lost reference flags error
// - Status flags clear only on written one
// - Failure flag stops trim, clears target
// - Lock flag set on lock, never interrupts
module rct_trim
  import rct_pkg::*;
#(
  parameter int REF_TMO_CYC = rct_pkg::RCT_REF_TMO_CYC
) (
  // Clock and reset
  input  wire  logic        clk,
  input  wire  logic        nrst,
  // Wishbone slave
  input  wire  logic        wb_cyc_i,
  input  wire  logic        wb_stb_i,
  input  wire  logic        wb_we_i,
  input  wire  logic [7:0]  wb_adr_i,
  input  wire  logic [3:0]  wb_sel_i,
  input  wire  logic [31:0] wb_dat_i,
  output logic       [31:0] wb_dat_o,
  output logic              wb_ack_o,
  // Reference clocks, asynchronous
  input  wire  logic        low_speed_crystal,
  input  wire  logic        usb_sof,
  // Gray-coded cycle count from the oscillator domain
  input  wire  logic [23:0] osc_gray,
  // Oscillator trim and interrupt
  output logic       [9:0]  fast_rc_oscillator_trim,
  output logic              irq
);
  import rct_pkg::*;

  // ****************************************************
  // State
  // ****************************************************
  rct_state_t s_q;
  rct_state_t s_d;

  logic        req;
  logic        wr_go;
  logic        en;
  logic        ref_lvl;
  logic        ref_edge;
  logic [23:0] osc_bin;
  logic [5:0]  win_len;
  logic [9:0]  limit;
  logic [23:0] per;
  logic [23:0] expect_cnt;
  logic [23:0] meas;
  logic [24:0] delta;
  logic [24:0] absd;
  logic        win_end;
  logic        near;
  logic        bad;
  logic        tmo_hit;
  logic        err_ev;
  logic        set_err;
  logic        set_fail;
  logic        set_lock;
  logic        clr_err;
  logic        clr_fail;
  logic        clr_lock;

  function automatic logic [23:0] gray2bin(input logic [23:0] g);
    logic [23:0] b;
    b[23] = g[23];
    for (int i = 22; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ****************************************************
  // Measurement datapath
  // ****************************************************
  assign req        = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master sees ack
  assign wr_go      = req & s_q.ack & wb_we_i;
  assign en         = (s_q.freq == RCT_FREQ_48M);
  assign ref_lvl    = s_q.refsel ? s_q.sof_s2 : s_q.xtal_s2;
  assign ref_edge   = ref_lvl & ~s_q.ref_prev;
  assign osc_bin    = gray2bin(s_q.osc_s2);
  assign win_len    = RCT_AVG_BASE << s_q.avg;
  assign limit      = RCT_RETRY_BASE << s_q.retry;
  assign per        = s_q.refsel ? RCT_PER_SOF : RCT_PER_XTAL;
  assign expect_cnt = per << ({1'b0, s_q.avg} + 3'd2);
  assign meas       = osc_bin - s_q.start;
  assign delta      = {1'b0, meas} - {1'b0, expect_cnt};
  assign absd       = delta[24] ? (25'd0 - delta) : delta;
  assign win_end    = en & s_q.armed & ref_edge & (s_q.per_cnt == win_len - 6'd1);
  // Quantisation of a crystal period is below one cycle, so allow one per period
  assign near       = (absd <= {19'd0, win_len});
  // Off by more than an eighth counts as unreasonable
  assign bad        = (absd > {4'd0, expect_cnt[23:3]});
  assign tmo_hit    = en & ~ref_edge & (32'(s_q.tmo) == REF_TMO_CYC - 1);
  assign err_ev     = (win_end & bad) | tmo_hit;

  // Software clear strobes for the status flags
  assign clr_err  = wr_go & (wb_adr_i[7:2] == RCT_OFS_STS[7:2]) & wb_sel_i[0]
                    & wb_dat_i[RCT_STS_ERR];
  assign clr_fail = wr_go & (wb_adr_i[7:2] == RCT_OFS_STS[7:2]) & wb_sel_i[0]
                    & wb_dat_i[RCT_STS_FAIL];
  assign clr_lock = wr_go & (wb_adr_i[7:2] == RCT_OFS_STS[7:2]) & wb_sel_i[0]
                    & wb_dat_i[RCT_STS_LOCK];

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    s_d      = s_q;
    set_err  = 1'b0;
    set_fail = 1'b0;
    set_lock = 1'b0;

    // Synchronisers; first stage feeds only the second
    s_d.xtal_s1  = low_speed_crystal;
    s_d.xtal_s2  = s_q.xtal_s1;
    s_d.sof_s1   = usb_sof;
    s_d.sof_s2   = s_q.sof_s1;
    s_d.osc_s1   = osc_gray;
    s_d.osc_s2   = s_q.osc_s1;
    s_d.ref_prev = ref_lvl;

    // Bus slave: one wait state, ack for one cycle
    s_d.ack = req & ~s_q.ack;
    if (req & ~s_q.ack) begin
      unique case (wb_adr_i[7:2])
        RCT_OFS_CTL[7:2]: s_d.rdat = {21'd0, s_q.refsel, 1'b0, s_q.stop, s_q.retry,
                                      s_q.avg, 2'b00, s_q.freq};
        RCT_OFS_IEN[7:2]: s_d.rdat = {29'd0, s_q.ie_clk, s_q.ie_fail, 1'b0};
        RCT_OFS_STS[7:2]: s_d.rdat = {29'd0, s_q.f_err, s_q.f_fail, s_q.f_lock};
        default:          s_d.rdat = 32'h0000_0000;
      endcase
    end
    if (wr_go & (wb_adr_i[7:2] == RCT_OFS_CTL[7:2])) begin
      if (wb_sel_i[0]) begin
        s_d.retry = wb_dat_i[RCT_CTL_RETRY +: 2];
        s_d.avg   = wb_dat_i[RCT_CTL_AVG +: 2];
        s_d.freq  = wb_dat_i[RCT_CTL_FREQ +: 2];
      end
      if (wb_sel_i[1]) begin
        s_d.stop   = wb_dat_i[RCT_CTL_STOP];
        s_d.refsel = wb_dat_i[RCT_CTL_REFSEL];
      end
    end
    if (wr_go & (wb_adr_i[7:2] == RCT_OFS_IEN[7:2]) & wb_sel_i[0]) begin
      s_d.ie_clk  = wb_dat_i[RCT_IEN_CLK];
      s_d.ie_fail = wb_dat_i[RCT_IEN_FAIL];
    end

    // Trim engine
    if (!en) begin
      s_d.armed    = 1'b0;
      s_d.per_cnt  = 6'd0;
      s_d.locked   = 1'b0;
      s_d.err_once = 1'b0;
      s_d.upd_cnt  = 10'd0;
      s_d.tmo      = 16'd0;
    end else begin
      if (ref_edge) begin
        s_d.tmo = 16'd0;
      end else if (32'(s_q.tmo) < REF_TMO_CYC) begin
        s_d.tmo = s_q.tmo + 16'd1;
      end
      if (ref_edge) begin
        if (!s_q.armed || win_end) begin
          s_d.armed   = 1'b1;
          s_d.per_cnt = 6'd0;
          s_d.start   = osc_bin;
        end else begin
          s_d.per_cnt = s_q.per_cnt + 6'd1;
        end
      end
      if (err_ev) begin
        if (s_q.stop) begin
          set_err    = 1'b1;
          s_d.freq   = RCT_FREQ_OFF;
          s_d.armed  = 1'b0;
        end else if (s_q.locked) begin
          // Report once, then hold the trim until a clean window
          set_err      = ~s_q.err_once;
          s_d.err_once = 1'b1;
        end else begin
          set_err = 1'b1;
        end
      end else if (win_end) begin
        s_d.err_once = 1'b0;
        if (near) begin
          set_lock    = 1'b1;
          s_d.locked  = 1'b1;
          s_d.upd_cnt = 10'd0;
        end else begin
          // Oscillator fast: count too high, so step down
          if (!delta[24] && s_q.trim != 10'h000) begin
            s_d.trim = s_q.trim - 10'd1;
          end else if (delta[24] && s_q.trim != 10'h3ff) begin
            s_d.trim = s_q.trim + 10'd1;
          end
          s_d.upd_cnt = s_q.upd_cnt + 10'd1;
          if (!s_q.locked && (s_q.upd_cnt + 10'd1 >= limit)) begin
            set_fail  = 1'b1;
            s_d.freq  = RCT_FREQ_OFF;
            s_d.armed = 1'b0;
          end
        end
      end
    end

    // Set wins over a clear in the same cycle
    s_d.f_err  = set_err  | (s_q.f_err  & ~clr_err);
    s_d.f_fail = set_fail | (s_q.f_fail & ~clr_fail);
    s_d.f_lock = set_lock | (s_q.f_lock & ~clr_lock);
    s_d.irq    = (s_d.f_err & s_d.ie_clk) | (s_d.f_fail & s_d.ie_fail);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q          <= '0;
      s_q.trim     <= RCT_TRIM_RST;
      s_q.refsel   <= RCT_CTL_RST[RCT_CTL_REFSEL];
      s_q.stop     <= RCT_CTL_RST[RCT_CTL_STOP];
      s_q.retry    <= RCT_CTL_RST[RCT_CTL_RETRY +: 2];
      s_q.avg      <= RCT_CTL_RST[RCT_CTL_AVG +: 2];
      s_q.freq     <= RCT_CTL_RST[RCT_CTL_FREQ +: 2];
      s_q.ie_clk   <= RCT_IEN_RST[RCT_IEN_CLK];
      s_q.ie_fail  <= RCT_IEN_RST[RCT_IEN_FAIL];
      s_q.f_err    <= RCT_STS_RST[RCT_STS_ERR];
      s_q.f_fail   <= RCT_STS_RST[RCT_STS_FAIL];
      s_q.f_lock   <= RCT_STS_RST[RCT_STS_LOCK];
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o                = s_q.rdat;
  assign wb_ack_o                = s_q.ack;
  assign fast_rc_oscillator_trim = s_q.trim;
  assign irq                     = s_q.irq;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_stop_clears;
    $rose(s_q.f_err) && $past(s_q.stop) && $past(en) |-> s_q.freq == RCT_FREQ_OFF;
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("error stop kept target");

  property p_err_once;
    s_q.err_once && s_q.locked && !s_q.stop && en |=> !$rose(s_q.f_err);
  endproperty
  a_err_once: assert property (p_err_once) else $error("error flag raised twice");

  property p_cnt_bound;
    !s_q.locked |-> s_q.upd_cnt <= limit;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("update count past limit");

  property p_lock_clears_cnt;
    $rose(s_q.locked) |-> s_q.upd_cnt == 10'd0;
  endproperty
  a_lock_clears_cnt: assert property (p_lock_clears_cnt) else $error("count kept at lock");

  property p_fail_clears;
    $rose(s_q.f_fail) |-> s_q.freq == RCT_FREQ_OFF && !s_q.armed;
  endproperty
  a_fail_clears: assert property (p_fail_clears) else $error("failure kept target");

  property p_window;
    s_q.per_cnt < win_len;
  endproperty
  a_window: assert property (p_window) else $error("window overran");

  property p_off_stable;
    !en |=> $stable(s_q.trim);
  endproperty
  a_off_stable: assert property (p_off_stable) else $error("trim moved while off");

  property p_w0_keeps;
    s_q.f_err && !clr_err ##1 1'b1 |-> s_q.f_err;
  endproperty
  a_w0_keeps: assert property (p_w0_keeps) else $error("error flag lost");

  property p_irq_clk;
    s_q.f_err && s_q.ie_clk |-> irq;
  endproperty
  a_irq_clk: assert property (p_irq_clk) else $error("clock error irq missing");

  property p_irq_lock;
    !s_q.f_err && !s_q.f_fail |-> !irq;
  endproperty
  a_irq_lock: assert property (p_irq_lock) else $error("irq without cause");

  property p_irq_fail;
    s_q.f_fail && s_q.ie_fail |-> irq;
  endproperty
  a_irq_fail: assert property (p_irq_fail) else $error("failure irq missing");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

  property p_ack_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acked");

  property p_ref_xtal;
    !s_q.refsel && $stable(s_q.refsel) && $rose(s_q.xtal_s2) |-> ref_edge;
  endproperty
  a_ref_xtal: assert property (p_ref_xtal) else $error("crystal edge missed");

  property p_ref_usb;
    s_q.refsel && !s_q.sof_s2 |-> !ref_edge;
  endproperty
  a_ref_usb: assert property (p_ref_usb) else $error("edge from unselected source");

  property p_no_stop;
    err_ev && !s_q.stop && !wr_go |=> s_q.freq == RCT_FREQ_48M;
  endproperty
  a_no_stop: assert property (p_no_stop) else $error("target lost without stop");

  property p_hold_err;
    err_ev |=> $stable(s_q.trim);
  endproperty
  a_hold_err: assert property (p_hold_err) else $error("trim moved on error");

  property p_lim_fail;
    win_end && !err_ev && !near && !s_q.locked && (s_q.upd_cnt + 10'd1 >= limit)
      |=> s_q.f_fail && s_q.freq == RCT_FREQ_OFF;
  endproperty
  a_lim_fail: assert property (p_lim_fail) else $error("limit reached, no failure");

  property p_off_idle;
    !en |=> s_q.upd_cnt == 10'd0 && !s_q.armed && !s_q.locked;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("engine busy while off");

  property p_err_sets;
    err_ev && (s_q.stop || !s_q.locked) |=> s_q.f_err;
  endproperty
  a_err_sets: assert property (p_err_sets) else $error("clock error not flagged");

  property p_clr_fail;
    s_q.f_fail && clr_fail && !set_fail |=> !s_q.f_fail;
  endproperty
  a_clr_fail: assert property (p_clr_fail) else $error("failure flag not cleared");

  property p_lock_sets;
    win_end && !err_ev && near |=> s_q.f_lock && s_q.upd_cnt == 10'd0;
  endproperty
  a_lock_sets: assert property (p_lock_sets) else $error("lock not flagged");

  property p_step_down;
    win_end && !err_ev && !near && !delta[24] && s_q.trim != 10'h000
      |=> s_q.trim == $past(s_q.trim) - 10'd1;
  endproperty
  a_step_down: assert property (p_step_down) else $error("trim not stepped down");

  property p_step_up;
    win_end && !err_ev && !near && delta[24] && s_q.trim != 10'h3ff
      |=> s_q.trim == $past(s_q.trim) + 10'd1;
  endproperty
  a_step_up: assert property (p_step_up) else $error("trim not stepped up");

endmodule

// ---- test/rct_osc_model.sv ----
`timescale 1ns/1ns
// ****
// Oscillator and reference source
// ****
module rct_osc_model #(
  parameter int REF_P = 40
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Scenario controls
  input  wire logic        usb,
  input  wire logic        stall,
  input  wire logic [9:0]  lock_trim,
  input  wire logic [9:0]  trim,
  // Reference pins and oscillator count
  output logic             xtal,
  output logic             sof,
  output logic      [23:0] gray
);
  int          ph;
  int          rate;
  logic [31:0] acc;
  // Two counts per period per trim step, so only the exact trim locks
  assign rate = ((usb ? 48000 : 1465) + 2 * (int'(trim) - int'(lock_trim))) * 256 / REF_P;
  assign gray = acc[31:8] ^ (acc[31:8] >> 1);
  // Reference period shrunk to REF_P clocks; oscillator scaled to match
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc <= 32'h0;
      ph  <= 0;
    end else begin
      acc <= acc + 32'(rate);
      ph  <= (ph == REF_P - 1) ? 0 : ph + 1;
    end
  end
  assign xtal = !usb && !stall && ph < REF_P / 2;
  assign sof  = usb && !stall && ph < 4;
endmodule

// ---- test/rct_trim_bench.sv ----
`timescale 1ns/1ns
module rct_trim_bench;
  import rct_pkg::*;
  // ****
  // Harness
  // ****
  localparam int TMO = 400;
  logic        clk, nrst, cyc, stb, we, ack, irq, xtal, sof, usb, stall;
  logic [7:0]  adr;
  logic [31:0] wd, rd, v;
  logic [9:0]  trim, lk, t;
  logic [23:0] gray;
  int          miscompares, checks, c;

  rct_trim #(.REF_TMO_CYC(TMO)) i_rct_trim (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack), .low_speed_crystal(xtal), .usb_sof(sof),
    .osc_gray(gray), .fast_rc_oscillator_trim(trim), .irq(irq));
  rct_osc_model i_rct_osc_model (.clk(clk), .nrst(nrst), .usb(usb), .stall(stall),
    .lock_trim(lk), .trim(trim), .xtal(xtal), .sof(sof), .gray(gray));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task rst;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
  endtask

  // Ack and read data taken at the rising edge, request dropped at that edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    v = rd;
    {cyc, stb} <= 2'b00;
    if (n >= 20) begin
      miscompares++;
      end_sim();
    end
  endtask

  task settle;
    repeat (2) @(negedge clk);
  endtask

  task wait_sts(input logic [31:0] m);
    int n;
    n = 0;
    do begin
      bus(1'b0, RCT_OFS_STS, 32'h0);
      n++;
    end while ((v & m) == 32'h0 && n < 8000);
    if (n >= 8000) begin
      miscompares++;
      end_sim();
    end
    settle();
  endtask

  task gap;
    t = trim;
    c = 0;
    while (trim === t && c < 2000) begin
      @(negedge clk);
      c++;
    end
    if (c >= 2000) begin
      miscompares++;
    end
  endtask

  // ****
  // Scenarios
  // ****
  task s_regs;
    settle();
    chk(trim, RCT_TRIM_RST);
    chk(irq, 32'h0);
    bus(1'b0, RCT_OFS_CTL, 32'h0);
    chk(v, RCT_CTL_RST);
    bus(1'b1, RCT_OFS_CTL, 32'hffff_fff1);
    bus(1'b0, RCT_OFS_CTL, 32'h0);
    chk(v, 32'h5f1);
    bus(1'b1, RCT_OFS_IEN, 32'hffff_ffff);
    bus(1'b0, RCT_OFS_IEN, 32'h0);
    chk(v, 32'h6);
    bus(1'b1, 8'h8c, 32'hffff_ffff);
    bus(1'b0, 8'h8c, 32'h0);
    chk(v, 32'h0);
    bus(1'b0, RCT_OFS_STS, 32'h0);
    chk(v, RCT_STS_RST);
    bus(1'b1, RCT_OFS_CTL, 32'h0);
    settle();
    chk(trim, RCT_TRIM_RST);
  endtask

  task s_lock;
    lk <= 10'h1fe;
    bus(1'b1, RCT_OFS_CTL, 32'h12);
    gap();
    gap();
    chk(c >= 320 && c <= 360, 32'h1);
    wait_sts(32'h1);
    chk(trim, 10'h1fe);
    chk(irq, 32'h0);
    bus(1'b1, RCT_OFS_CTL, 32'h0);
    bus(1'b1, RCT_OFS_STS, 32'h0);
    bus(1'b0, RCT_OFS_STS, 32'h0);
    chk(v, 32'h1);
    bus(1'b1, RCT_OFS_STS, 32'h1);
    bus(1'b0, RCT_OFS_STS, 32'h0);
    chk(v, 32'h0);
    lk <= 10'h210;
    repeat (400) @(negedge clk);
    chk(trim, 10'h1fe);
  endtask

  task s_fail;
    lk <= 10'h250;
    bus(1'b1, RCT_OFS_IEN, 32'h2);
    bus(1'b1, RCT_OFS_CTL, 32'h2);
    wait_sts(32'h2);
    chk(trim, 10'h240);
    chk(irq, 32'h1);
    bus(1'b0, RCT_OFS_CTL, 32'h0);
    chk(v, 32'h0);
    bus(1'b1, RCT_OFS_IEN, 32'h0);
    settle();
    chk(irq, 32'h0);
    bus(1'b1, RCT_OFS_STS, 32'h2);
  endtask

  task s_err_stop;
    usb <= 1'b1;
    lk <= trim;
    bus(1'b1, RCT_OFS_IEN, 32'h4);
    bus(1'b1, RCT_OFS_CTL, 32'h502);
    wait_sts(32'h1);
    stall <= 1'b1;
    wait_sts(32'h4);
    chk(irq, 32'h1);
    bus(1'b0, RCT_OFS_CTL, 32'h0);
    chk(v, 32'h500);
    bus(1'b1, RCT_OFS_STS, 32'h5);
    settle();
    chk(irq, 32'h0);
    stall <= 1'b0;
  endtask

  task s_err_once;
    usb <= 1'b0;
    bus(1'b1, RCT_OFS_CTL, 32'h2);
    wait_sts(32'h1);
    stall <= 1'b1;
    wait_sts(32'h4);
    t = trim;
    bus(1'b1, RCT_OFS_STS, 32'h4);
    // Recovery brings one bad window, which must stay silent
    stall <= 1'b0;
    repeat (1200) @(negedge clk);
    bus(1'b0, RCT_OFS_STS, 32'h0);
    chk(v[2], 32'h0);
    chk(trim, t);
    bus(1'b0, RCT_OFS_CTL, 32'h0);
    chk(v, 32'h2);
  endtask

  initial begin
    {nrst, cyc, stb, we, usb, stall} = 6'h0;
    adr = 8'h0;
    wd = 32'h0;
    lk = RCT_TRIM_RST;
    miscompares = 0;
    checks = 0;
    rst();
    s_regs();
    s_lock();
    rst();
    s_fail();
    s_err_stop();
    s_err_once();
    end_sim();
  end
endmodule
